// ---- shared/nand_host_params.svh ----
// Constants for the flash host controller: opcodes, address layout, timing
`ifndef NAND_HOST_PARAMS_SVH
`define NAND_HOST_PARAMS_SVH

// ==========================================================
// Opcodes
`define OP_READ_SETUP      8'h00
`define OP_READ_CONFIRM    8'h30
`define OP_COPYBACK_READ   8'h35
`define OP_STATUS          8'h70
`define OP_COLUMN_OUT      8'h05
`define OP_COLUMN_OUT_END  8'he0
`define OP_PLANE_SELECT    8'h06
`define OP_RESET           8'hff

// ==========================================================
// Address layout
`define ADDR_CYCLES        3'd5
`define COL_BITS           12
`define ROW_BITS           17
`define PLANE_ROW_POS      6
`define STATUS_READY_BIT   6

// ==========================================================
// Timing, in ns and in cycles of a 10 ns clock
`define CLK_PERIOD_NS      10
`define STROBE_LOW_NS      20
`define STROBE_HIGH_NS     20
`define STROBE_LOW_CYC     ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC    ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_BYTES         2176
`define FIFO_DEPTH         32

`endif

// ---- shared/nand_host_pkg.sv ----
// Types for the flash host controller
package nand_host_pkg;

   // ==========================================================
   // Bus pins toward the flash
   typedef struct packed {
      logic       chip_sel_n;
      logic       cmd_latch;
      logic       addr_latch;
      logic       write_strobe_n;
      logic       read_strobe_n;
      logic       write_protect_n;
   } flash_ctl_t;

   // ==========================================================
   // Read request from the user side
   typedef struct packed {
      logic        use_status_poll;
      logic        skip_setup;
      logic [11:0] column;
      logic [16:0] row;
      logic [11:0] byte_count;
   } read_req_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_CONFIRM, ST_WAIT_BUSY, ST_WAIT_READY,
      ST_POLL_CMD, ST_POLL_READ, ST_RESUME, ST_DATA, ST_DONE
   } host_state_t;

endpackage

// ---- logic/nand_host_fifo.sv ----
// Data buffer between the flash read path and the user side
`timescale 1ns/1ns
module nand_host_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem[rd_ptr_r];

   always_ff @(posedge core_clk) begin
      if (push) mem[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ---- logic/nand_host_reader.sv ----
// Host controller that issues page reads to the flash and streams out the bytes
// Notes on behaviour
// [RULE1] Column bits 0-11 in address cycles one-two
// [RULE2] Row bits 12-28 in cycles three to five
// [RULE3] Unused bits of cycles two, five driven low
// [RULE4] Row bit 18 selects the plane
// [RULE5] Extra address cycles ignored by the flash
// [RULE6] Latch pins select command, address or data
// [RULE7] Page read is 00h, five addresses, 30h
// [RULE8] First read after power-on may skip 00h; the code skips 00h on any request with skip_setup set
// [RULE9] Flash holds ready low during transfer
// [RULE10] Host may poll status 70h instead
// [RULE11] After polling, reissue 00h before reading data
// [RULE12] Read one byte per read strobe pulse
// [RULE13] Output runs sequentially to page end
// [RULE14] Copy-back uses 85h..10h and 00h-35h
// [RULE15] Legacy two-plane erase 60h,60h,D0h
// [RULE16] Standard two-plane erase 60h,D1h,60h,D0h
// [RULE17] Plane data select uses 06h..E0h
// [RULE18] Two-plane copy-back read 00h..00h..35h
// [RULE19] Two-plane copy-back program 85h,11h,81h/85h,10h
// [RULE20] Host issues only listed opcodes
// [RULE21] Column change stays within current page
// [RULE22] Copy-back keeps the same plane bit
// [RULE23] Flash latches bytes on strobe rising edge
// [RULE24] Write protect low blocks program and erase
// [RULE25] Chip select high floats the flash bus
`timescale 1ns/1ns
`include "nand_host_params.svh"
module nand_host_reader
   import nand_host_pkg::*;
#(
   parameter int FIFO_WIDTH = 8,
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter int PAGE_BYTES = `PAGE_BYTES
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rstn,
   // Read request
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire read_req_t             req,
   // Read data stream
   output logic                       data_valid,
   input  wire logic                  data_ready,
   output logic [FIFO_WIDTH-1:0]      data_byte,
   output logic                       read_done,
   // Flash control pins
   output flash_ctl_t                 flash_ctl,
   input  wire logic                  ready_busy_n,
   // Flash data bus, three signals
   input  wire logic [7:0]            bus_in,
   output logic [7:0]                 bus_out,
   output logic                       bus_oe
);
   localparam int LOW_CYC  = `STROBE_LOW_CYC;
   localparam int HIGH_CYC = `STROBE_HIGH_CYC;

   host_state_t state_r;
   host_state_t state_nxt;
   read_req_t   req_r;
   logic [2:0]  addr_idx_r;
   logic [11:0] left_r;
   logic [1:0]  phase_cnt_r;
   logic        strobe_low_r;
   logic [7:0]  bus_out_r;
   logic        oe_r;
   logic        cle_r;
   logic        ale_r;
   logic        done_r;

   // ==========================================================
   // Strobe timing: one byte slot is a low half then a high half
   wire slot_end  = !strobe_low_r && (phase_cnt_r == 2'(HIGH_CYC - 1));
   wire low_end   = strobe_low_r && (phase_cnt_r == 2'(LOW_CYC - 1));
   wire in_write  = (state_r == ST_CMD) || (state_r == ST_ADDR) ||
                    (state_r == ST_CONFIRM) || (state_r == ST_POLL_CMD) ||
                    (state_r == ST_RESUME);
   wire in_read   = (state_r == ST_POLL_READ) || (state_r == ST_DATA);
   wire fifo_ready;
   wire fifo_push = (state_r == ST_DATA) && low_end;

   // ==========================================================
   // Address byte selection
   wire [7:0] addr_byte =
      (addr_idx_r == 3'd0) ? req_r.column[7:0] :                    // [RULE1]
      (addr_idx_r == 3'd1) ? {4'h0, req_r.column[11:8]} :           // [RULE1] [RULE3]
      (addr_idx_r == 3'd2) ? req_r.row[7:0] :                       // [RULE2] [RULE4]
      (addr_idx_r == 3'd3) ? req_r.row[15:8] :                      // [RULE2]
                             {7'h00, req_r.row[16]};                // [RULE2] [RULE3]

   // Page end clamp: never request beyond the last byte
   wire [12:0] room = 13'(PAGE_BYTES) - {1'b0, req.column};
   wire [11:0] first_count =
      ({1'b0, req.byte_count} > room) ? room[11:0] : req.byte_count; // [RULE13]

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:       if (req_valid)
                           state_nxt = req.skip_setup ? ST_ADDR : ST_CMD; // [RULE8]
         ST_CMD:        if (slot_end) state_nxt = ST_ADDR;
         ST_ADDR:       if (slot_end && addr_idx_r == `ADDR_CYCLES - 3'd1)
                           state_nxt = ST_CONFIRM;                // [RULE7]
         ST_CONFIRM:    if (slot_end)
                           state_nxt = req_r.use_status_poll ? ST_POLL_CMD : ST_WAIT_BUSY;
         ST_WAIT_BUSY:  if (!ready_busy_n) state_nxt = ST_WAIT_READY; // [RULE9]
         ST_WAIT_READY: if (ready_busy_n) state_nxt = ST_DATA;        // [RULE9]
         ST_POLL_CMD:   if (slot_end) state_nxt = ST_POLL_READ;       // [RULE10]
         ST_POLL_READ:  if (low_end && bus_in[`STATUS_READY_BIT])
                           state_nxt = ST_RESUME;
         ST_RESUME:     if (slot_end) state_nxt = ST_DATA;            // [RULE11]
         ST_DATA:       if (slot_end && left_r == 12'd0) state_nxt = ST_DONE;
         ST_DONE:       state_nxt = ST_IDLE;
      endcase
   end

   // ==========================================================
   // Strobe phase counter; stalls in the low half while the buffer is full
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phase_cnt_r  <= 2'h0;
         strobe_low_r <= 1'b0;
      end else if (!(in_write || in_read) || (state_nxt != state_r)) begin
         // Any change of state opens a fresh slot, so a status hit still strobes 00h
         phase_cnt_r  <= 2'h0;
         strobe_low_r <= 1'b1;
      end else if (low_end && !(state_r == ST_DATA && !fifo_ready)) begin
         phase_cnt_r  <= 2'h0;
         strobe_low_r <= 1'b0;
      end else if (slot_end) begin
         phase_cnt_r  <= 2'h0;
         strobe_low_r <= 1'b1;
      end else if (!low_end) begin
         phase_cnt_r  <= phase_cnt_r + 2'h1;
      end
   end

   // ==========================================================
   // Request capture and counters
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_r       <= '0;
         addr_idx_r  <= 3'd0;
         left_r      <= 12'd0;
         done_r      <= 1'b0;
      end else begin
         done_r <= (state_r == ST_DONE);
         if (state_r == ST_IDLE && req_valid) begin
            req_r       <= req;
            req_r.byte_count <= first_count;
            // Bytes still to take; the slot that empties it is the last
            left_r      <= (first_count == 12'd0) ? 12'd1 : first_count;
            addr_idx_r  <= 3'd0;
         end
         if (state_r == ST_ADDR && slot_end) addr_idx_r <= addr_idx_r + 3'd1;
         if (fifo_push && fifo_ready && left_r != 12'd0) left_r <= left_r - 12'd1; // [RULE12] [RULE13]
      end
   end

   // ==========================================================
   // Pin drive: data and latches registered, strobes from the phase
   // Read opcodes only: copy-back, erase and plane select never leave here
   wire [7:0] cmd_byte =                                        // [RULE14] [RULE15] [RULE16]
      (state_r == ST_CMD)      ? `OP_READ_SETUP :                 // [RULE7] [RULE20]
      (state_r == ST_CONFIRM)  ? `OP_READ_CONFIRM :               // [RULE7]
      (state_r == ST_POLL_CMD) ? `OP_STATUS :                     // [RULE10]
      (state_r == ST_RESUME)   ? `OP_READ_SETUP :                 // [RULE11]
                                 addr_byte; // [RULE17] [RULE18] [RULE19] [RULE21] [RULE22]

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_out_r <= 8'h00;
         oe_r      <= 1'b0;
         cle_r     <= 1'b0;
         ale_r     <= 1'b0;
      end else begin
         bus_out_r <= cmd_byte;
         oe_r      <= in_write;
         cle_r     <= in_write && (state_r != ST_ADDR);               // [RULE6]
         ale_r     <= (state_r == ST_ADDR);                           // [RULE6]
      end
   end

   assign flash_ctl.chip_sel_n      = (state_r == ST_IDLE);           // [RULE25]
   assign flash_ctl.cmd_latch       = cle_r && in_write;
   assign flash_ctl.addr_latch      = ale_r && in_write;
   // Full low half on every slot; only the rising edge latches
   assign flash_ctl.write_strobe_n  = !(in_write && strobe_low_r);   // [RULE23]
   assign flash_ctl.read_strobe_n   = !(in_read && strobe_low_r);     // [RULE6] [RULE12]
   assign flash_ctl.write_protect_n = 1'b0;                           // Reads only [RULE24]
   assign bus_out   = bus_out_r;
   assign bus_oe    = oe_r && in_write;
   assign req_ready = (state_r == ST_IDLE);
   assign read_done = done_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) state_r <= ST_IDLE;
      else       state_r <= state_nxt;
   end

   // ==========================================================
   // Read data buffer; a full buffer holds the read strobe low
   nand_host_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .in_valid  (fifo_push),
      .in_ready  (fifo_ready),
      .in_data   (FIFO_WIDTH'(bus_in)),
      .out_valid (data_valid),
      .out_ready (data_ready),
      .out_data  (data_byte)
   );
endmodule

// ---- tb/nand_host_reader_checker.sv ----
// Protocol checker for the flash read host
`timescale 1ns/1ns
`include "nand_host_params.svh"
module nand_host_reader_checker
   import nand_host_pkg::*;
(
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // Watched ports
   input wire logic       read_done,
   input wire flash_ctl_t flash_ctl,
   input wire logic [7:0] bus_out,
   input wire logic       bus_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Strobe edges and address count
   logic       ws_q;
   logic [2:0] addr_cnt_r;
   logic       stat_r;
   wire wr_rise  = flash_ctl.write_strobe_n & ~ws_q & ~flash_ctl.chip_sel_n;
   wire cmd_rise = wr_rise & flash_ctl.cmd_latch;
   wire adr_rise = wr_rise & flash_ctl.addr_latch;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ws_q <= 1'b1;
         addr_cnt_r <= 3'h0;
         stat_r <= 1'b0;
      end else begin
         ws_q <= flash_ctl.write_strobe_n;
         if (cmd_rise) addr_cnt_r <= 3'h0;
         else if (adr_rise && addr_cnt_r != 3'h7) addr_cnt_r <= addr_cnt_r + 3'h1;
         if (cmd_rise) stat_r <= bus_out == `OP_STATUS;
      end
   end
   // ==========================================================
   // Properties
   property p_latch_excl;
      flash_ctl.cmd_latch || flash_ctl.addr_latch |->
         flash_ctl.read_strobe_n && (flash_ctl.cmd_latch != flash_ctl.addr_latch);
   endproperty
   a_latch_excl: assert property (p_latch_excl) else $error("latch pins clash");
   property p_read_mode;
      !flash_ctl.read_strobe_n |-> !bus_oe;
   endproperty
   a_read_mode: assert property (p_read_mode) else $error("host drives during read");
   property p_latch_hold;
      $rose(flash_ctl.write_strobe_n) && (flash_ctl.cmd_latch || flash_ctl.addr_latch)
         |-> $past(bus_oe) && $stable(bus_out);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("byte unstable at latch");
   property p_we_low;
      $fell(flash_ctl.write_strobe_n) |=> !flash_ctl.write_strobe_n ##1 flash_ctl.write_strobe_n;
   endproperty
   a_we_low: assert property (p_we_low) else $error("write strobe width wrong");
   property p_re_low;
      $fell(flash_ctl.read_strobe_n) |=> !flash_ctl.read_strobe_n;
   endproperty
   a_re_low: assert property (p_re_low) else $error("read strobe too short");
   property p_five_addr;
      cmd_rise && bus_out == `OP_READ_CONFIRM |-> addr_cnt_r == 3'd5;
   endproperty
   a_five_addr: assert property (p_five_addr) else $error("confirm not after five");
   property p_no_extra;
      adr_rise |-> addr_cnt_r < 3'd5;
   endproperty
   a_no_extra: assert property (p_no_extra) else $error("extra address cycle");
   property p_pad_low;
      adr_rise && (addr_cnt_r == 3'd1 || addr_cnt_r == 3'd4) |->
         (addr_cnt_r == 3'd1) ? bus_out[7:4] == 4'h0 : bus_out[7:1] == 7'h00;
   endproperty
   a_pad_low: assert property (p_pad_low) else $error("unused address bits set");
   property p_opcodes;
      cmd_rise |-> bus_out inside {`OP_READ_SETUP, `OP_READ_CONFIRM, `OP_STATUS};
   endproperty
   a_opcodes: assert property (p_opcodes) else $error("unexpected opcode");
   property p_resume;
      read_done |-> !stat_r;
   endproperty
   a_resume: assert property (p_resume) else $error("data read in status mode");
endmodule
bind nand_host_reader nand_host_reader_checker u_nand_host_reader_checker (
   .core_clk(core_clk), .rstn(rstn), .read_done(read_done),
   .flash_ctl(flash_ctl), .bus_out(bus_out), .bus_oe(bus_oe));

// ---- tb/nand_flash_model.sv ----
// Behavioural flash device answering page reads
`timescale 1ns/1ns
module nand_flash_model
   import nand_host_pkg::*;
(
   // Busy timer clock
   input  wire logic       core_clk,
   // Host side
   input  wire flash_ctl_t ctl,
   input  wire logic [7:0] host_data,
   input  wire logic       host_oe,
   input  wire logic [7:0] busy_len,
   // Device side
   output logic            ready_busy_n,
   output logic [7:0]      bus_in,
   output logic            proto_err
);
   // ==========================================================
   // Command and address capture
   logic [7:0]  cmd_r = 8'h00;
   logic [7:0]  adr_r [5];
   logic [11:0] col_r = 12'h000;
   logic [16:0] row_r = 17'h00000;
   logic [7:0]  dout_r = 8'h00;
   logic [7:0]  busy_r = 8'h00;
   logic        go_r = 1'b0;
   logic        go_q = 1'b0;
   logic        stat_r = 1'b0;
   logic        err_w = 1'b0;
   logic        err_r = 1'b0;
   int          n_adr = 0;
   int          n_rd = 0;
   int          base = 0;
   // Offset kept apart so only the read strobe moves the column
   wire [11:0] col_now = col_r + 12'(n_rd - base);
   // Strobe edges seen at the clock, so zero-width glitches never latch
   logic        ws_q = 1'b1;
   logic        re_q = 1'b1;
   wire         wr_rise = ctl.write_strobe_n && !ws_q && !ctl.chip_sel_n;
   wire         rd_fall = !ctl.read_strobe_n && re_q && !ctl.chip_sel_n;
   wire         rd_rise = ctl.read_strobe_n && !re_q && !ctl.chip_sel_n;
   function automatic logic [7:0] byte_at(logic [16:0] r, logic [11:0] c);
      logic [7:0] b;
      b = r[7:0] ^ r[15:8] ^ c[7:0] ^ {3'h0, r[16], c[11:8]};
      return r[6] ? ~b : b;
   endfunction
   always @(posedge core_clk) begin
      ws_q <= ctl.write_strobe_n;
      if (wr_rise && ctl.cmd_latch && !ctl.addr_latch) begin
         // Program and erase are refused while write protect is low
         if (!ctl.write_protect_n && host_data inside {8'h80, 8'h85, 8'h60})
            err_w <= 1'b1;
         if (host_data == 8'h30) begin
            err_w <= err_w | cmd_r != 8'h00 | n_adr < 5;
            col_r <= {adr_r[1][3:0], adr_r[0]};
            row_r <= {adr_r[4][0], adr_r[3], adr_r[2]};
            base <= n_rd;
            go_r <= ~go_r;
         end
         if (host_data == 8'h00) n_adr <= 0;
         stat_r <= host_data == 8'h70;
         cmd_r <= host_data;
      end else if (wr_rise && ctl.addr_latch && !ctl.cmd_latch) begin
         if (n_adr < 5) adr_r[n_adr] <= host_data;
         err_w <= err_w | (n_adr == 1 && host_data[7:4] != 4'h0)
                        | (n_adr == 4 && host_data[7:1] != 7'h00);
         n_adr <= n_adr + 1;
      end
   end
   always @(posedge core_clk) begin
      if (go_q != go_r) begin
         busy_r <= busy_len;
         go_q <= go_r;
      end else if (busy_r != 8'h00) busy_r <= busy_r - 8'h01;
   end
   assign ready_busy_n = busy_r == 8'h00 && go_q == go_r;
   always @(posedge core_clk) begin
      re_q <= ctl.read_strobe_n;
      if (rd_fall) begin
         if (!stat_r && !ready_busy_n) err_r <= 1'b1;
         dout_r <= stat_r ? {1'b0, ready_busy_n, 6'h00} : byte_at(row_r, col_now);
      end
      if (rd_rise && !stat_r) n_rd <= n_rd + 1;
   end
   // Released bus shows the inverse so a stale byte never matches
   assign bus_in = host_oe ? host_data :
                   (!ctl.chip_sel_n && !ctl.read_strobe_n) ? dout_r : ~dout_r;
   assign proto_err = err_w | err_r;
endmodule

// ---- tb/nand_host_reader_test.sv ----
// Self-checking bench for the flash read host
`timescale 1ns/1ns
`include "nand_host_params.svh"
module nand_host_reader_test
   import nand_host_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        req_valid = 1'b0;
   logic        data_ready = 1'b0;
   logic        stall = 1'b0;
   read_req_t   req = '0;
   logic [7:0]  busy_len = 8'h04;
   logic [31:0] seed = 32'h178eeacd;
   logic [31:0] rv;
   logic [7:0]  expq [$];
   int          miscompares = 0;
   int          samples_checked = 0;
   int          dones = 0;
   wire         data_valid, req_ready, read_done, bus_oe, ready_busy_n, proto_err;
   wire [7:0]   data_byte, bus_in, bus_out;
   flash_ctl_t  flash_ctl;
   always #5 core_clk = ~core_clk;
   nand_host_reader u_nand_host_reader (.core_clk(core_clk), .rstn(rstn),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .data_valid(data_valid),
      .data_ready(data_ready), .data_byte(data_byte), .read_done(read_done),
      .flash_ctl(flash_ctl), .ready_busy_n(ready_busy_n), .bus_in(bus_in),
      .bus_out(bus_out), .bus_oe(bus_oe));
   nand_flash_model u_nand_flash_model (.core_clk(core_clk), .ctl(flash_ctl),
      .host_data(bus_out), .host_oe(bus_oe), .busy_len(busy_len),
      .ready_busy_n(ready_busy_n), .bus_in(bus_in), .proto_err(proto_err));
   // ==========================================================
   // Helpers
   function logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] exp_byte(logic [16:0] r, logic [11:0] c);
      logic [7:0] b;
      b = r[7:0] ^ r[15:8] ^ c[7:0] ^ {3'h0, r[16], c[11:8]};
      return r[6] ? ~b : b;
   endfunction
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (rstn) data_ready <= !stall && xorshift() % 3 != 0;
      if (data_valid === 1'b1 && data_ready === 1'b1) check(data_byte, expq.pop_front());
      if (read_done === 1'b1) dones++;
   end
   task automatic do_read(logic [11:0] col, logic [16:0] row, logic [11:0] cnt, logic poll,
                          logic skip);
      int n;
      int d0;
      int t;
      n = (cnt == 0) ? 1 : cnt;
      if (n > `PAGE_BYTES - col) n = `PAGE_BYTES - col;
      for (int i = 0; i < n; i++) expq.push_back(exp_byte(row, col + 12'(i)));
      d0 = dones;
      t = 0;
      busy_len <= 8'(xorshift() % 50 + 1);
      req <= '{poll, skip, col, row, cnt};
      req_valid <= 1'b1;
      do begin
         @(negedge core_clk);
         t++;
      end while (req_ready !== 1'b1 && t < 1000);
      check(req_ready, 1'b1);
      @(posedge core_clk);
      req_valid <= 1'b0;
      @(negedge core_clk);
      check(req_ready, 1'b0);
      // Long stall lets the buffer fill; the strobe must wait, not drop bytes
      if (stall) begin
         repeat (2000) @(posedge core_clk);
         check(data_valid, 1'b1);
         stall <= 1'b0;
      end
      while ((dones == d0 || expq.size() != 0) && t < 30000) begin
         @(posedge core_clk);
         t++;
      end
      check(16'(dones - d0), 16'd1);
      $display("test col %h row %h bytes %0d done", col, row, n);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      do_read(12'h010, 17'h00040, 12'd8, 1'b0, 1'b1);
      do_read(12'h87e, 17'h1ffff, 12'd20, 1'b0, 1'b0);
      do_read(12'h123, 17'h0abcd, 12'd0, 1'b0, 1'b0);
      do_read(12'h400, 17'h10fbf, 12'd12, 1'b1, 1'b0);
      stall <= 1'b1;
      do_read(12'h000, 17'h10000, 12'd40, 1'b0, 1'b0);
      repeat (10) begin
         rv = xorshift();
         do_read(12'(rv % 2176), 17'(xorshift()), 12'(rv[31:24] % 40), rv[12], 1'b0);
      end
      check(proto_err, 1'b0);
      conclude();
   end
   initial begin
      #500000;
      miscompares++;
      conclude();
   end
endmodule
